/* src/fdc_config_reg.sv */
// fast deceleration configuration register with decoded settings
`timescale 1ns/10ps

module fdc_config_reg (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [fdc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fdc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [fdc_pkg::GAIN_W-1:0] sense_amp_gain,
    input wire logic decel_active,
    input wire logic bemf_comparator_output,
    output logic [fdc_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output fdc_pkg::fdc_cfg_s cfg,
    output logic bemf_comparator_gated,
    output logic current_limit_valid,
    output logic [fdc_pkg::MA_W-1:0] current_limit_ma
);
    import fdc_pkg::*;

    // ------------------------------------------------------------
    // register storage and read port
    // ------------------------------------------------------------
    logic [DATA_W-1:0] cfg_reg_q;
    logic [DATA_W-1:0] cfg_reg_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic hit;

    always_comb begin
        hit = (reg_addr == FDC_CFG_ADDR);
        cfg_reg_d = cfg_reg_q;
        if (reg_wr && hit) begin
            // every bit, reserved and parity included, is read-write
            cfg_reg_d = reg_wdata;
        end
        rvalid_d = reg_rd;
        // unmapped reads return zero
        rdata_d = (reg_rd && hit) ? cfg_reg_q : '0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_reg_q <= FDC_CFG_RESET;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            cfg_reg_q <= cfg_reg_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic [2:0] win_code;
    logic [2:0] thr_code;
    logic [3:0] low_code;
    logic [3:0] up_code;
    logic [2:0] exit_code;
    logic [PM_W-1:0] win_pm;
    logic [PM_W-1:0] thr_pm;
    logic [PM_W-1:0] exit_pm;
    logic low_valid;
    logic up_valid;
    logic [MV_W-1:0] low_mv;
    logic [MV_W-1:0] up_mv;
    logic [MA_W-1:0] low_ma;
    logic [MA_W-1:0] up_ma;
    fdc_cfg_s cfg_d;
    fdc_cfg_s cfg_q;

    assign win_code = cfg_reg_q[DUTY_WIN_LSB +: 3];
    assign thr_code = cfg_reg_q[DUTY_THR_LSB +: 3];
    assign low_code = cfg_reg_q[LOW_LIM_LSB +: 4];
    assign up_code = cfg_reg_q[UP_LIM_LSB +: 4];
    assign exit_code = cfg_reg_q[EXIT_DELTA_LSB +: 3];

    // the three percentage fields are plain table lookups
    fdc_table_pick #(.SEL_W(3), .VAL_W(PM_W), .TABLE(DUTY_WIN_PM)) u_win_pick (
        .sel(win_code),
        .value(win_pm)
    );
    fdc_table_pick #(.SEL_W(3), .VAL_W(PM_W), .TABLE(DUTY_THR_PM)) u_thr_pick (
        .sel(thr_code),
        .value(thr_pm)
    );
    fdc_table_pick #(.SEL_W(3), .VAL_W(PM_W), .TABLE(EXIT_DELTA_PM)) u_exit_pick (
        .sel(exit_code),
        .value(exit_pm)
    );

    // each current limit field has its own instance of the code-to-amperes scaler
    fdc_limit_scale #(.CODE_W(4), .GAIN_BITS(GAIN_W), .VOLT_W(MV_W), .AMP_W(MA_W)) u_low_scale (
        .code(low_code),
        .gain(sense_amp_gain),
        .valid(low_valid),
        .mv(low_mv),
        .ma(low_ma)
    );
    fdc_limit_scale #(.CODE_W(4), .GAIN_BITS(GAIN_W), .VOLT_W(MV_W), .AMP_W(MA_W)) u_up_scale (
        .code(up_code),
        .gain(sense_amp_gain),
        .valid(up_valid),
        .mv(up_mv),
        .ma(up_ma)
    );

    always_comb begin
        cfg_d.decel_enable = cfg_reg_q[DECEL_EN_BIT];
        cfg_d.blank_enable = cfg_reg_q[BLANK_EN_BIT];
        cfg_d.dyn_limit_enable = cfg_reg_q[DYN_EN_BIT];
        cfg_d.duty_window_pm = win_pm;
        cfg_d.duty_threshold_pm = thr_pm;
        cfg_d.exit_delta_pm = exit_pm;
        cfg_d.low_lim_valid = low_valid;
        cfg_d.low_lim_mv = low_mv;
        cfg_d.low_lim_ma = low_ma;
        cfg_d.up_lim_valid = up_valid;
        cfg_d.up_lim_mv = up_mv;
        cfg_d.up_lim_ma = up_ma;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // comparator blanking and active current limit
    // ------------------------------------------------------------
    // the comparator is analog and asynchronous to clk
    logic cmp_meta_q;
    logic cmp_sync_q;
    logic gated_d;
    logic gated_q;
    logic lim_valid_d;
    logic lim_valid_q;
    logic [MA_W-1:0] lim_ma_d;
    logic [MA_W-1:0] lim_ma_q;
    logic use_low;

    always_comb begin
        gated_d = cmp_sync_q & ~(cfg_q.blank_enable & cfg_q.decel_enable & decel_active);
        // reduced limit applies only while slowing down and when a lower code is set
        use_low = cfg_q.dyn_limit_enable & cfg_q.decel_enable & decel_active & cfg_q.low_lim_valid;
        if (use_low) begin
            lim_valid_d = 1'b1;
            lim_ma_d = cfg_q.low_lim_ma;
        end else begin
            lim_valid_d = cfg_q.up_lim_valid;
            lim_ma_d = cfg_q.up_lim_valid ? cfg_q.up_lim_ma : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
            gated_q <= 1'b0;
            lim_valid_q <= 1'b0;
            lim_ma_q <= '0;
        end else begin
            cmp_meta_q <= bemf_comparator_output;
            cmp_sync_q <= cmp_meta_q;
            gated_q <= gated_d;
            lim_valid_q <= lim_valid_d;
            lim_ma_q <= lim_ma_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign cfg = cfg_q;
    assign bemf_comparator_gated = gated_q;
    assign current_limit_valid = lim_valid_q;
    assign current_limit_ma = lim_ma_q;

endmodule

// ------------------------------------------------------------
// table lookup for a coded percentage field
// ------------------------------------------------------------
module fdc_table_pick #(
    parameter int SEL_W = 3,
    parameter int VAL_W = fdc_pkg::PM_W,
    parameter logic [(1<<SEL_W)-1:0][VAL_W-1:0] TABLE = '0
) (
    input wire logic [SEL_W-1:0] sel,
    output logic [VAL_W-1:0] value
);
    import fdc_pkg::*;

    always_comb begin
        value = TABLE[sel];
    end

endmodule

// ------------------------------------------------------------
// current limit scaling: code to millivolts, then milliamperes
// ------------------------------------------------------------
module fdc_limit_scale #(
    parameter int CODE_W = 4,
    parameter int GAIN_BITS = fdc_pkg::GAIN_W,
    parameter int VOLT_W = fdc_pkg::MV_W,
    parameter int AMP_W = fdc_pkg::MA_W,
    parameter logic [VOLT_W-1:0] STEP_MV = fdc_pkg::LIM_STEP_MV,
    parameter logic [VOLT_W-1:0] SCALE = fdc_pkg::MA_PER_A
) (
    input wire logic [CODE_W-1:0] code,
    input wire logic [GAIN_BITS-1:0] gain,
    output logic valid,
    output logic [VOLT_W-1:0] mv,
    output logic [AMP_W-1:0] ma
);
    import fdc_pkg::*;

    logic [31:0] ma_wide;

    always_comb begin
        // code zero means the limit is not applicable
        valid = (code != '0);
        mv = VOLT_W'(code) * STEP_MV;
        // a zero gain would divide by zero, so the limit reads as zero then
        if (gain == '0) begin
            ma_wide = '0;
        end else begin
            // 32 bits hold the largest code times the scale without overflow
            ma_wide = (32'(mv) * 32'(SCALE)) / 32'(gain);
        end
        ma = AMP_W'(ma_wide);
    end

endmodule

/* pkg/fdc_pkg.sv */
// package of constants and types for the fast deceleration configuration register
package fdc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] FDC_CFG_ADDR = 8'h8c;
    localparam logic [DATA_W-1:0] FDC_CFG_RESET = 32'h00000000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PARITY_BIT = 31;
    localparam int BLANK_EN_BIT = 19;
    localparam int DUTY_WIN_LSB = 16;
    localparam int DUTY_THR_LSB = 13;
    localparam int LOW_LIM_LSB = 9;
    localparam int DYN_EN_BIT = 8;
    localparam int DECEL_EN_BIT = 7;
    localparam int UP_LIM_LSB = 3;
    localparam int EXIT_DELTA_LSB = 0;

    // ------------------------------------------------------------
    // decoded value widths and scaling
    // ------------------------------------------------------------
    localparam int PM_W = 10;          // tenths of a percent, up to 1000
    localparam int MV_W = 11;          // millivolts, up to 1500
    localparam int MA_W = 24;          // milliamperes
    localparam int GAIN_W = 16;        // sense gain in mV per A
    localparam logic [MV_W-1:0] LIM_STEP_MV = 11'h064;      // 100 mV per code
    localparam logic [MV_W-1:0] MA_PER_A = 11'h3e8;         // 1000

    // duty window in tenths of a percent, codes 0..7
    localparam logic [7:0][PM_W-1:0] DUTY_WIN_PM = {
        10'h0fa, 10'h0c8, 10'h096, 10'h064, 10'h04b, 10'h032, 10'h019, 10'h000};
    // duty threshold in tenths of a percent, 1000 down to 650
    localparam logic [7:0][PM_W-1:0] DUTY_THR_PM = {
        10'h28a, 10'h2bc, 10'h2ee, 10'h320, 10'h352, 10'h384, 10'h3b6, 10'h3e8};
    // exit speed delta in tenths of a percent
    localparam logic [7:0][PM_W-1:0] EXIT_DELTA_PM = {
        10'h032, 10'h028, 10'h01e, 10'h019, 10'h014, 10'h00f, 10'h00a, 10'h005};

    // ------------------------------------------------------------
    // decoded settings handed to the control algorithm
    // ------------------------------------------------------------
    typedef struct packed {
        logic decel_enable;
        logic blank_enable;
        logic dyn_limit_enable;
        logic [PM_W-1:0] duty_window_pm;
        logic [PM_W-1:0] duty_threshold_pm;
        logic [PM_W-1:0] exit_delta_pm;
        logic low_lim_valid;
        logic [MV_W-1:0] low_lim_mv;
        logic [MA_W-1:0] low_lim_ma;
        logic up_lim_valid;
        logic [MV_W-1:0] up_lim_mv;
        logic [MA_W-1:0] up_lim_ma;
    } fdc_cfg_s;

endpackage

/* bench/fdc_config_reg_props.sv */
// assertions for the fast deceleration configuration register
`timescale 1ns/10ps
module fdc_config_reg_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [fdc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fdc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [fdc_pkg::GAIN_W-1:0] sense_amp_gain,
    input wire logic decel_active,
    input wire logic [fdc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input fdc_pkg::fdc_cfg_s cfg,
    input wire logic bemf_comparator_gated,
    input wire logic [fdc_pkg::MA_W-1:0] current_limit_ma
);
    import fdc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic hit_wr;
    logic hit_rd;
    logic act;
    assign hit_wr = reg_wr && reg_addr == FDC_CFG_ADDR;
    assign hit_rd = reg_rd && reg_addr == FDC_CFG_ADDR;
    assign act = cfg.decel_enable && decel_active;
    sequence s_wr_then_rd;
        hit_wr ##1 (hit_rd && !reg_wr);
    endsequence
    chk_rd_answer: assert property (1 |=> reg_rvalid == $past(reg_rd))
        else $error("read answer timing wrong");
    chk_miss_zero: assert property (!hit_rd |=> reg_rdata == '0)
        else $error("read data not zero");
    chk_write_back: assert property (s_wr_then_rd |=> reg_rdata == $past(reg_wdata, 2))
        else $error("written word not read back");
    chk_enable_bits: assert property (hit_wr |-> ##2
        {cfg.blank_enable, cfg.dyn_limit_enable, cfg.decel_enable} ==
        {$past(reg_wdata[19], 2), $past(reg_wdata[8], 2), $past(reg_wdata[7], 2)}) else $error("enable bits wrong");
    chk_low_code: assert property (hit_wr |-> ##2
        cfg.low_lim_mv == 11'($past(reg_wdata[12:9], 2)) * LIM_STEP_MV
        && cfg.low_lim_valid == ($past(reg_wdata[12:9], 2) != 0)) else $error("lower limit decode wrong");
    chk_up_code: assert property (hit_wr |-> ##2
        cfg.up_lim_mv == 11'($past(reg_wdata[6:3], 2)) * LIM_STEP_MV
        && cfg.up_lim_valid == ($past(reg_wdata[6:3], 2) != 0)) else $error("upper limit decode wrong");
    chk_low_amps: assert property (sense_amp_gain != 0 |=>
        cfg.low_lim_ma == 32'(cfg.low_lim_mv) * 1000 / $past(sense_amp_gain)) else $error("amps conversion wrong");
    chk_comparator_blanked: assert property (cfg.blank_enable && act |=> !bemf_comparator_gated)
        else $error("comparator not blanked");
    chk_dyn_limit: assert property (cfg.dyn_limit_enable && act && cfg.low_lim_valid |=>
        current_limit_ma == $past(cfg.low_lim_ma)) else $error("dynamic limit not applied");
endmodule
bind fdc_config_reg fdc_config_reg_props u_props (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .sense_amp_gain, .decel_active, .reg_rdata, .reg_rvalid, .cfg, .bemf_comparator_gated, .current_limit_ma);

/* bench/test_fdc_config_reg.sv */
// self-checking bench for the fast deceleration configuration register
`timescale 1ns/10ps
`define CHK(a, b) \
    begin \
        tests_run++; \
        if ((a) !== (b)) begin \
            miscompares++; \
            $display("[FAIL] %0t mismatch", $time); \
        end \
    end
module test_fdc_config_reg;
    import fdc_pkg::*;
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, decel_active = 0, bemf_comparator_output = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, w, mdl = '0;
    logic [GAIN_W-1:0] sense_amp_gain = 16'h00c8;
    logic reg_rvalid, bemf_comparator_gated, current_limit_valid, on;
    logic [MA_W-1:0] current_limit_ma;
    fdc_cfg_s cfg;
    logic [DATA_W-1:0] exp_q[$];
    int miscompares = 0, tests_run = 0, cycles = 0;
    int win[8] = '{0, 25, 50, 75, 100, 150, 200, 250};
    int ext[8] = '{5, 10, 15, 20, 25, 30, 40, 50};
    fdc_config_reg dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .sense_amp_gain, .decel_active,
        .bemf_comparator_output, .reg_rdata, .reg_rvalid, .cfg, .bemf_comparator_gated, .current_limit_valid,
        .current_limit_ma);
    // ----------------------------------------
    // bus driver and read monitor
    // ----------------------------------------
    task automatic op(input logic w_en, input logic r_en, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_wr = w_en;
        reg_rd = r_en;
        reg_addr = a;
        reg_wdata = d;
        // a read in the same cycle as a write still sees the old word
        if (r_en)
            exp_q.push_back(a == FDC_CFG_ADDR ? mdl : '0);
        if (w_en && a == FDC_CFG_ADDR)
            mdl = d;
        @(negedge clk);
    endtask
    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        #1;
        if (reg_rvalid === 1'b1) begin
            `CHK(reg_rdata, exp_q.pop_front())
        end
        cycles++;
        if (cycles > 2000) begin
            miscompares++;
            stop_test();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(30896));
        repeat (6) @(negedge clk);
        rst_n = 1;
        op(0, 1, 8'h8c, '0);
        for (int i = 0; i < 16; i++) begin
            sense_amp_gain = 16'($urandom_range(1000, 1));
            w = $urandom;
            w[18:16] = i[2:0];
            w[15:13] = i[2:0];
            w[12:9] = i[3:0];
            w[6:3] = 4'(15 - i);
            w[2:0] = i[2:0];
            op(1, 0, 8'h8c, w);
            op(0, 1, 8'h8c, '0);
            op(0, 0, 8'h8c, '0);
            `CHK({cfg.blank_enable, cfg.decel_enable}, {w[19], w[7]})
            `CHK(cfg.dyn_limit_enable, w[8])
            `CHK(cfg.duty_window_pm, 10'(win[i % 8]))
            `CHK(cfg.duty_threshold_pm, 10'(1000 - 50 * (i % 8)))
            `CHK(cfg.exit_delta_pm, 10'(ext[i % 8]))
            `CHK(cfg.low_lim_valid, i != 0)
            `CHK(cfg.low_lim_ma, 24'(i * 100000 / sense_amp_gain))
            `CHK(cfg.up_lim_ma, 24'((15 - i) * 100000 / sense_amp_gain))
            `CHK(current_limit_valid, i != 15)
            `CHK(current_limit_ma, 24'((15 - i) * 100000 / sense_amp_gain))
        end
        // unmapped accesses are ignored, then a read racing a write
        op(1, 0, 8'h8d, 32'hffffffff);
        op(0, 1, 8'h8d, '0);
        op(1, 1, 8'h8c, '0);
        sense_amp_gain = 16'h0064;
        bemf_comparator_output = 1;
        for (int k = 0; k < 4; k++) begin
            on = k[1] & k[0];
            decel_active = k[0];
            op(1, 0, 8'h8c, k[1] ? 32'h80080bd0 : 32'h80000ad0);
            op(0, 1, 8'h8c, '0);
            op(0, 0, 8'h8c, '0);
            repeat (3) @(negedge clk);
            `CHK(current_limit_ma, on ? 24'h001388 : 24'h002710)
            `CHK(current_limit_valid, 1'b1)
            `CHK(bemf_comparator_gated, !on)
        end
        // a zero gain must give zero amperes rather than a divide fault
        sense_amp_gain = '0;
        repeat (2) @(negedge clk);
        `CHK({cfg.low_lim_ma, cfg.up_lim_ma}, 48'h0)
        // a reset in mid-run clears the word written above
        rst_n = 0;
        repeat (2) @(negedge clk);
        rst_n = 1;
        mdl = '0;
        op(0, 1, 8'h8c, '0);
        op(0, 0, 8'h8c, '0);
        `CHK({cfg.decel_enable, cfg.blank_enable, cfg.dyn_limit_enable, current_limit_valid}, 4'h0)
        `CHK(cfg.duty_threshold_pm, 10'h3e8)
        `CHK(exp_q.size(), 0)
        repeat (2) @(negedge clk);
        stop_test();
    end
endmodule
